// *** stu_accum.sv ***
`timescale 1ns/1ps
module stu_accum (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Addend
   input  wire logic        load,
   input  wire logic [31:0] addend_in,
   // Carry pulse
   output logic             pulse
);

   logic [31:0] addend;
   logic [31:0] acc;
   logic [32:0] next_sum;

   assign next_sum = {1'b0, acc} + {1'b0, addend};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addend <= 32'h0000_0000;
         acc    <= 32'h0000_0000;
         pulse  <= 1'b0;
      end else if (ce) begin
         if (load) begin
            addend <= addend_in;
         end
         acc   <= next_sum[31:0];
         pulse <= next_sum[32];
      end
   end

endmodule

// *** stu_pkg.sv ***
package stu_pkg;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_FINE_BIT   = 1;
   localparam int          CTRL_INIT_BIT   = 2;
   localparam int          CTRL_UPD_BIT    = 3;
   localparam int          CTRL_TARGET_TIME_INTERRUPT_ARM_BIT   = 4;
   localparam int          CTRL_ADDEND_BIT = 5;
   localparam int          CTRL_SSSR_BIT   = 9;
   localparam logic [31:0] CTRL_RST        = 32'h0000_2000;
   localparam logic [31:0] CTRL_WMASK      = 32'h0000_023F;

   // ------------------------------------------------------------
   // Fields in neighbouring registers
   // ------------------------------------------------------------
   localparam int          MASK_TRIG_BIT   = 9;
   localparam int          REMAP_LSB       = 10;
   localparam logic [1:0]  REMAP_TRIG_ONE  = 2'h1;
   localparam int          MISC_PPS_BIT    = 9;
   localparam int          UPD_SIGN_BIT    = 31;
   localparam int          FREQ_W          = 4;

   // ------------------------------------------------------------
   // Subsecond rollover limits
   // ------------------------------------------------------------
   localparam logic [31:0] SUB_ROLL_BIN    = 32'h8000_0000;
   localparam logic [31:0] SUB_ROLL_DIG    = 32'h3B9A_CA00;

   // ------------------------------------------------------------
   // Pulse-per-second high times
   // ------------------------------------------------------------
   localparam longint      PPS_HIGH_BIN_MS = 125;
   localparam longint      PPS_HIGH_DIG_MS = 100;
   localparam longint      MS_PER_S        = 1000;
   localparam logic [31:0] PPS_HIGH_BIN    =
      32'(longint'(SUB_ROLL_BIN) * PPS_HIGH_BIN_MS / MS_PER_S);
   localparam logic [31:0] PPS_HIGH_DIG    =
      32'(longint'(SUB_ROLL_DIG) * PPS_HIGH_DIG_MS / MS_PER_S);

endpackage

// *** stu_pps.sv ***
`timescale 1ns/1ps
module stu_pps (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      ce,
   // Time and settings
   stu_time_if.sink                       tm,
   input  wire logic [stu_pkg::FREQ_W-1:0] exponent,
   input  wire logic                      alt_source,
   // Output
   output logic                           pps
);

   logic [31:0] shifted;
   logic        one_hz_high;
   logic        fast_high;
   logic        next_pps;

   // Bit 30 of the subsecond count has a one-second period; each step of
   // the exponent halves the period and keeps the duty at half.
   assign shifted     = tm.sub >> (5'd30 - {1'b0, exponent});
   assign fast_high   = ~shifted[0];
   assign one_hz_high = tm.digital ? (tm.sub < stu_pkg::PPS_HIGH_DIG)
                                   : (tm.sub < stu_pkg::PPS_HIGH_BIN);
   // Digital rollover has no binary bit to divide, so it stays at 1 Hz
   assign next_pps = !alt_source &&
                     ((exponent == 4'h0 || tm.digital) ? one_hz_high : fast_high);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pps <= 1'b0;
      end else if (ce) begin
         pps <= next_pps;
      end
   end

endmodule

// *** stu_time_if.sv ***
`timescale 1ns/1ps
interface stu_time_if;
   logic [31:0] sec;
   logic [31:0] sub;
   logic        digital;

   modport src  (output sec, output sub, output digital);
   modport sink (input  sec, input  sub, input  digital);
endinterface

// *** stu_time_unit.sv ***
`timescale 1ns/1ps
// What this block does
// - Time is 32-bit seconds plus 32-bit subseconds
// - Addend accumulator carry produces one update pulse
// - Each update adds subsecond increment to count
// - Control bit 0 enables timestamping
// - Bit 5 loads addend, then self-clears
// - Bit 1 selects fine, otherwise every clock
// - Bit 2 loads update registers, then self-clears
// - Bit 3 adds signed offset, then self-clears
// - Mask bit 9 blocks trigger interrupt
// - Bit 4 arms target-time comparison
// - Trigger interrupt when time exceeds target
// - Reading interrupt status clears trigger flag
// - Trigger output high when time exceeds target
// - Remap 01 routes trigger to timer input
// - Binary pulse rate is two to exponent hertz; digital stays 1 Hz
// - 1 Hz width 125 ms binary, 100 ms digital
// - Binary 2 Hz and up gives half duty
// - Pulse behaviour only when misc bit 9 clear
// - Two interrupt outputs: main and wakeup
// - Wakeup and line 19 assert together
module stu_time_unit (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Control register write port
   input  wire logic        ctrl_wr,
   input  wire logic [31:0] ctrl_wdata,
   output logic      [31:0] time_stamp_control_reg,
   // Software-held settings
   input  wire logic [7:0]  sub_increment,
   input  wire logic [31:0] frequency_addend_reg,
   input  wire logic [31:0] time_update_high_reg,
   input  wire logic [31:0] time_update_low_reg,
   input  wire logic [31:0] target_high,
   input  wire logic [31:0] target_low,
   input  wire logic [31:0] mac_interrupt_mask_reg,
   input  wire logic [31:0] pulse_per_second_control_reg,
   input  wire logic [31:0] clock_unit_misc_reg,
   input  wire logic [31:0] timer_input_remap_reg,
   // Interrupt status read
   input  wire logic        int_status_rd,
   output logic             trig_flag,
   // System time
   output logic      [31:0] time_sec,
   output logic      [31:0] time_sub,
   // Trigger and pulse outputs
   output logic             trigger_out,
   output logic             timer_trigger_input_one,
   output logic             pps_out,
   // Interrupt sources and outputs
   input  wire logic        mac_dma_event,
   input  wire logic        wake_event,
   input  wire logic        wake_irq_en,
   input  wire logic        exint19_rise_en,
   output logic             irq_main,
   output logic             irq_wakeup,
   output logic             external_interrupt_line
);

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   wire       ts_enable  = time_stamp_control_reg[stu_pkg::CTRL_EN_BIT];
   wire       fine_mode  = time_stamp_control_reg[stu_pkg::CTRL_FINE_BIT];
   wire       init_req   = time_stamp_control_reg[stu_pkg::CTRL_INIT_BIT];
   wire       upd_req    = time_stamp_control_reg[stu_pkg::CTRL_UPD_BIT];
   wire       armed      = time_stamp_control_reg[stu_pkg::CTRL_TARGET_TIME_INTERRUPT_ARM_BIT];
   wire       addend_req = time_stamp_control_reg[stu_pkg::CTRL_ADDEND_BIT];
   wire       digital    = time_stamp_control_reg[stu_pkg::CTRL_SSSR_BIT];
   wire       trig_mask  = mac_interrupt_mask_reg[stu_pkg::MASK_TRIG_BIT];
   wire       pps_alt    = clock_unit_misc_reg[stu_pkg::MISC_PPS_BIT];
   wire [1:0] remap      = timer_input_remap_reg[stu_pkg::REMAP_LSB +: 2];
   wire [31:0] roll      = digital ? stu_pkg::SUB_ROLL_DIG : stu_pkg::SUB_ROLL_BIN;

   // ------------------------------------------------------------
   // Fine correction pulse
   // ------------------------------------------------------------
   logic acc_pulse;

   stu_accum u_accum (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .load      (addend_req),
      .addend_in (frequency_addend_reg),
      .pulse     (acc_pulse)
   );

   // ------------------------------------------------------------
   // Normal advance
   // ------------------------------------------------------------
   wire        advance  = ts_enable && (fine_mode ? acc_pulse : 1'b1);
   wire [32:0] inc_sum  = {1'b0, time_sub} + {25'h000_0000, sub_increment};
   wire        inc_roll = inc_sum >= {1'b0, roll};
   wire [31:0] adv_sub  = inc_roll ? 32'h0000_0000 : inc_sum[31:0];
   wire [31:0] adv_sec  = time_sec + {31'h0000_0000, inc_roll};

   // ------------------------------------------------------------
   // Offset update: low bit 31 selects subtraction
   // ------------------------------------------------------------
   wire        off_neg  = time_update_low_reg[stu_pkg::UPD_SIGN_BIT];
   wire [32:0] off_sub  = {2'h0, time_update_low_reg[30:0]};
   wire [32:0] add_sum  = {1'b0, time_sub} + off_sub;
   wire        add_cy   = add_sum >= {1'b0, roll};
   wire [32:0] add_fix  = add_cy ? add_sum - {1'b0, roll} : add_sum;
   wire        sub_bw   = {1'b0, time_sub} < off_sub;
   wire [32:0] sub_base = sub_bw ? {1'b0, time_sub} + {1'b0, roll} : {1'b0, time_sub};
   wire [32:0] sub_diff = sub_base - off_sub;
   wire [31:0] off_nsub = off_neg ? sub_diff[31:0] : add_fix[31:0];
   wire [31:0] off_nsec = off_neg ?
                          time_sec - time_update_high_reg - {31'h0000_0000, sub_bw} :
                          time_sec + time_update_high_reg + {31'h0000_0000, add_cy};

   // ------------------------------------------------------------
   // Next time selection: initialize wins over offset
   // ------------------------------------------------------------
   logic [31:0] next_sec;
   logic [31:0] next_sub;

   always_comb begin
      next_sec = time_sec;
      next_sub = time_sub;
      if (init_req) begin
         next_sec = time_update_high_reg;
         next_sub = {1'b0, time_update_low_reg[30:0]};
      end else if (upd_req) begin
         next_sec = off_nsec;
         next_sub = off_nsub;
      end else if (advance) begin
         next_sec = adv_sec;
         next_sub = adv_sub;
      end
   end

   // ------------------------------------------------------------
   // Control register with self-clearing commands
   // ------------------------------------------------------------
   logic [31:0] ctrl_done;
   logic [31:0] next_ctrl;

   assign ctrl_done = {26'h000_0000, addend_req, 1'b0, upd_req, init_req, 2'h0};
   // A write in the cycle a command completes still sets the new command
   assign next_ctrl = ctrl_wr ?
                      (ctrl_wdata & stu_pkg::CTRL_WMASK) |
                      (stu_pkg::CTRL_RST & ~stu_pkg::CTRL_WMASK) :
                      time_stamp_control_reg & ~ctrl_done;

   // ------------------------------------------------------------
   // Target comparison and trigger
   // ------------------------------------------------------------
   wire past_target = {time_sec, time_sub} > {target_high, target_low};
   wire next_trig   = armed && past_target;
   wire trig_rise   = next_trig && !trigger_out;
   // Set wins over the clearing read
   wire next_flag   = trig_rise || (trig_flag && !int_status_rd);
   wire next_main   = (next_flag && !trig_mask) || mac_dma_event;

   // ------------------------------------------------------------
   // Wakeup interrupts share one decision so both rise together
   // ------------------------------------------------------------
   wire next_wake   = wake_event && wake_irq_en;
   wire next_external_interrupt_line  = next_wake && !irq_wakeup && exint19_rise_en;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         time_stamp_control_reg  <= stu_pkg::CTRL_RST;
         time_sec                <= 32'h0000_0000;
         time_sub                <= 32'h0000_0000;
         trigger_out             <= 1'b0;
         trig_flag               <= 1'b0;
         irq_main                <= 1'b0;
         timer_trigger_input_one <= 1'b0;
         irq_wakeup              <= 1'b0;
         external_interrupt_line <= 1'b0;
      end else if (ce) begin
         time_stamp_control_reg  <= next_ctrl;
         time_sec                <= next_sec;
         time_sub                <= next_sub;
         trigger_out             <= next_trig;
         trig_flag               <= next_flag;
         irq_main                <= next_main;
         timer_trigger_input_one <= next_trig && (remap == stu_pkg::REMAP_TRIG_ONE);
         irq_wakeup              <= next_wake;
         external_interrupt_line <= next_external_interrupt_line;
      end
   end

   // ------------------------------------------------------------
   // Pulse per second
   // ------------------------------------------------------------
   stu_time_if tm ();

   assign tm.sec     = time_sec;
   assign tm.sub     = time_sub;
   assign tm.digital = digital;

   stu_pps u_pps (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .tm         (tm),
      .exponent   (pulse_per_second_control_reg[stu_pkg::FREQ_W-1:0]),
      .alt_source (pps_alt),
      .pps        (pps_out)
   );

endmodule

// *** stu_time_unit_sva.sv ***
`timescale 1ns/1ps
module stu_time_unit_sva (
   // Clock and control
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        ctrl_wr,
   input  wire logic [31:0] ctrl_wdata,
   input  wire logic [31:0] time_stamp_control_reg,
   // Settings
   input  wire logic [7:0]  sub_increment,
   input  wire logic [31:0] target_high,
   input  wire logic [31:0] target_low,
   input  wire logic [31:0] mac_interrupt_mask_reg,
   input  wire logic [31:0] pulse_per_second_control_reg,
   input  wire logic [31:0] clock_unit_misc_reg,
   // Events and outputs
   input  wire logic        int_status_rd,
   input  wire logic        mac_dma_event,
   input  wire logic        wake_event,
   input  wire logic        wake_irq_en,
   input  wire logic        exint19_rise_en,
   input  wire logic        trig_flag,
   input  wire logic [31:0] time_sec,
   input  wire logic [31:0] time_sub,
   input  wire logic        trigger_out,
   input  wire logic        pps_out,
   input  wire logic        irq_main,
   input  wire logic        irq_wakeup,
   input  wire logic        external_interrupt_line
);
   wire [31:0] r   = time_stamp_control_reg;
   wire        run = ce && !ctrl_wr && r[0] && !r[1] && !r[2] && !r[3];
   wire [32:0] sum = {1'b0, time_sub} + {25'h0, sub_increment};
   wire [32:0] lim = {1'b0, r[9] ? stu_pkg::SUB_ROLL_DIG : stu_pkg::SUB_ROLL_BIN};
   wire [3:0]  ex  = pulse_per_second_control_reg[3:0];
   wire        ppf = clock_unit_misc_reg[9] ? 1'b0 : r[9] ? time_sub < stu_pkg::PPS_HIGH_DIG :
                     ex == 4'h0 ? time_sub < stu_pkg::PPS_HIGH_BIN : !time_sub[5'd30 - {1'b0, ex}];

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence late_s;
      ce && r[4] && {time_sec, time_sub} > {target_high, target_low};
   endsequence
   sequence wake_s;
      ce && wake_event && wake_irq_en && exint19_rise_en && !irq_wakeup;
   endsequence

   ctrl_write_a: assert property (
      ce && ctrl_wr |=> r == (($past(ctrl_wdata) & stu_pkg::CTRL_WMASK) | stu_pkg::CTRL_RST))
      else $error("control write mismatch");
   self_clear_a: assert property (
      ce && !ctrl_wr && (r & 32'h0000_002C) != 32'h0 |=> (r & 32'h0000_002C) == 32'h0)
      else $error("command bit did not clear");
   coarse_step_a: assert property (
      run && sum < lim |=> time_sub == $past(sum[31:0]) && $stable(time_sec))
      else $error("coarse step wrong");
   sub_roll_a: assert property (
      run && sum >= lim |=> time_sub == 32'h0 && time_sec == $past(time_sec) + 32'h1)
      else $error("rollover wrong");
   trig_set_a: assert property (late_s |=> trigger_out)
      else $error("trigger missing");
   flag_rise_a: assert property ($rose(trigger_out) |-> trig_flag)
      else $error("flag missing");
   flag_clear_a: assert property (
      ce && int_status_rd |=> !trig_flag || $rose(trigger_out))
      else $error("flag not cleared");
   irq_mask_a: assert property (
      ce && mac_interrupt_mask_reg[9] && !mac_dma_event |=> !irq_main)
      else $error("masked irq seen");
   wake_pair_a: assert property (wake_s |=> irq_wakeup && external_interrupt_line)
      else $error("wake pair missing");
   pps_track_a: assert property (rst_n && ce |=> pps_out == $past(ppf))
      else $error("pps wrong");
endmodule

bind stu_time_unit stu_time_unit_sva chk (.*);

// *** stu_time_unit_tb_top.sv ***
`timescale 1ns/1ps
module stu_time_unit_tb_top;
   logic        clk, rst_n, ce, ctrl_wr, int_status_rd, mac_dma_event, wake_event;
   logic        wake_irq_en, exint19_rise_en, trig_flag, trigger_out, timer_trigger_input_one;
   logic        pps_out, irq_main, irq_wakeup, external_interrupt_line;
   logic [7:0]  sub_increment, inc;
   logic [31:0] ctrl_wdata, frequency_addend_reg, time_update_high_reg, time_update_low_reg;
   logic [31:0] target_high, target_low, mac_interrupt_mask_reg, pulse_per_second_control_reg;
   logic [31:0] clock_unit_misc_reg, timer_input_remap_reg, time_stamp_control_reg;
   logic [31:0] time_sec, time_sub, hi, lo, es, eu, s0, pc, mo, mi, u;
   int          miscompares, check_count, seed, i;

   stu_time_unit dut (.*);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ------
   // Helpers
   // ------
   task automatic chk(string nm, logic [95:0] e, logic [95:0] g);
      check_count++;
      if (e !== g) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(logic [31:0] d, logic [31:0] h, logic [31:0] l);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= d;
      time_update_high_reg <= h;
      time_update_low_reg <= l;
      @(posedge clk);
      ctrl_wr <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Sub borrows or carries at the binary limit
   function automatic logic [63:0] exp_off(logic [31:0] s, logic [31:0] v, logic [31:0] h,
                                           logic [31:0] l);
      logic [32:0] t;
      t = v + l[30:0];
      if (!l[31]) return t >= 33'h0_8000_0000 ? {s + h + 32'h1, t[31:0] - 32'h8000_0000}
                                              : {s + h, t[31:0]};
      return v < l[30:0] ? {s - h - 32'h1, v + 32'h8000_0000 - l[30:0]} : {s - h, v - l[30:0]};
   endfunction
   function automatic logic exp_pps(logic [31:0] v, logic d, logic [3:0] n, logic off);
      if (off) return 1'b0;
      if (d) return v < stu_pkg::PPS_HIGH_DIG;
      if (n == 4'h0) return v < stu_pkg::PPS_HIGH_BIN;
      return !v[5'd30 - {1'b0, n}];
   endfunction

   initial begin
      cyc(20000);
      miscompares++;
      give_verdict();
   end

   // ------
   // Main sequence
   // ------
   initial begin
      seed = 57;
      miscompares = 0;
      check_count = 0;
      {rst_n, ctrl_wr, int_status_rd, mac_dma_event, wake_event, wake_irq_en} = '0;
      {exint19_rise_en, ctrl_wdata, frequency_addend_reg, time_update_high_reg} = '0;
      {time_update_low_reg, target_high, target_low, mac_interrupt_mask_reg} = '0;
      {pulse_per_second_control_reg, clock_unit_misc_reg, timer_input_remap_reg} = '0;
      sub_increment = 8'h0;
      ce = 1'b1;
      cyc(3);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset", {32'h2000, 64'h0}, {time_stamp_control_reg, time_sec, time_sub});
      inc = 8'($random(seed)) | 8'h1;
      hi = $random(seed);
      lo = $random(seed) & 32'h0FFF_FFFF;
      @(posedge clk);
      sub_increment <= inc;
      wr(32'h5, hi, lo);
      cyc(1);
      @(negedge clk);
      chk("init", {32'h2001, hi, lo}, {time_stamp_control_reg, time_sec, time_sub});
      cyc(7);
      @(negedge clk);
      chk("coarse", {hi, lo + 32'(inc) * 7}, {time_sec, time_sub});
      // Clock enable low must hold the time where it is
      @(posedge clk);
      ce <= 1'b0;
      cyc(5);
      @(negedge clk);
      chk("freeze", {hi, lo + 32'(inc) * 8}, {time_sec, time_sub});
      @(posedge clk);
      ce <= 1'b1;
      for (i = 0; i < 2; i++) begin
         lo = i ? stu_pkg::SUB_ROLL_DIG : stu_pkg::SUB_ROLL_BIN;
         wr(32'h5 | (32'(i) << 9), hi, lo - 32'(inc) * 2);
         cyc(3);
         @(negedge clk);
         chk("rollover", {hi + 32'h1, 32'h0}, {time_sec, time_sub});
      end
      $display("count test done");
      @(posedge clk);
      sub_increment <= 8'h0;
      wr(32'h5, hi, lo);
      {es, eu} = {hi, lo};
      for (i = 0; i < 6; i++) begin
         pc = $random(seed);
         mi = $random(seed);
         wr(32'h9, pc, mi);
         cyc(1);
         @(negedge clk);
         {es, eu} = exp_off(es, eu, pc, mi);
         chk("offset", {32'h2001, es, eu}, {time_stamp_control_reg, time_sec, time_sub});
      end
      $display("offset test done");
      @(posedge clk);
      sub_increment <= inc;
      wr(32'h5, 32'h0, 32'h0);
      for (i = 1; i < 3; i++) begin
         @(posedge clk);
         frequency_addend_reg <= 32'h8000_0000 >> (i - 1);
         wr(32'h23, 32'h0, 32'h0);
         cyc(4);
         @(negedge clk);
         s0 = time_sub;
         cyc(40);
         @(negedge clk);
         chk("fine", {32'h2003, s0 + 32'(inc) * (20 / i)}, {time_stamp_control_reg, time_sub});
      end
      $display("fine test done");
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         sub_increment <= 8'h1;
         {target_high, target_low} <= {hi, 32'h100};
         mac_interrupt_mask_reg <= 32'(i) << 9;
         timer_input_remap_reg <= 32'h400;
         wr(32'h15, hi, 32'hFB);
         cyc(7);
         @(negedge clk);
         chk("early", 1'b0, trigger_out);
         cyc(1);
         @(negedge clk);
         chk("trigger", 2'b11, {trigger_out, trig_flag});
         cyc(1);
         @(negedge clk);
         chk("irq", i == 0, irq_main);
         cyc(1);
         @(negedge clk);
         chk("timer in", 1'b1, timer_trigger_input_one);
         @(posedge clk);
         int_status_rd <= 1'b1;
         timer_input_remap_reg <= 32'h0;
         @(posedge clk);
         int_status_rd <= 1'b0;
         cyc(2);
         @(negedge clk);
         chk("clear", 2'b00, {trig_flag, timer_trigger_input_one});
      end
      $display("trigger test done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         wake_irq_en <= i[0];
         exint19_rise_en <= i[1];
         wake_event <= 1'b1;
         cyc(1);
         @(negedge clk);
         chk("wake", {i[0], i[0] & i[1]}, {irq_wakeup, external_interrupt_line});
         @(posedge clk);
         wake_event <= 1'b0;
         cyc(1);
      end
      @(posedge clk);
      mac_dma_event <= 1'b1;
      cyc(2);
      @(negedge clk);
      chk("mac irq", 1'b1, irq_main);
      $display("interrupt test done");
      for (i = 0; i < 24; i++) begin
         pc = $random(seed);
         mo = $random(seed) & 32'h200;
         mi = $random(seed);
         u = $unsigned($random(seed)) % stu_pkg::SUB_ROLL_DIG;
         if (i < 4) begin
            pc[3:0] = 4'h0;
            mi[9] = 1'b0;
            u = (mo[9] ? stu_pkg::PPS_HIGH_DIG : stu_pkg::PPS_HIGH_BIN) - 32'(i % 2);
         end
         @(posedge clk);
         pulse_per_second_control_reg <= pc;
         clock_unit_misc_reg <= mi;
         wr(32'h5 | mo, hi, u);
         cyc(2);
         @(negedge clk);
         chk("pps", exp_pps(u, mo[9], pc[3:0], mi[9]), pps_out);
      end
      $display("pps test done");
      give_verdict();
   end
endmodule
